// [design/pho_defines.vh]
`ifndef PHO_DEFINES_VH
`define PHO_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PHO_IDX_LDC 10'h018
`define PHO_IDX_LPS 10'h01a
`define PHO_IDX_MPT 10'h01b
`define PHO_IDX_RSC 10'h01c
`define PHO_IDX_HOC 10'h01d
`define PHO_IDX_STS 10'h01f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PHO_RST_LDC 8'h00
`define PHO_RST_LPS 8'h00
`define PHO_RST_MPT 8'h00
`define PHO_RST_RSC 8'h00
`define PHO_RST_HOC 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PHO_LDC_CNT_HI 6
`define PHO_LDC_CNT_LO 5
`define PHO_LDC_WIN 4
`define PHO_LDC_DLD_DIS 3
`define PHO_LPS_SEL_HI 5
`define PHO_LPS_SEL_LO 0
`define PHO_MPT_THR_HI 7
`define PHO_MPT_THR_LO 5
`define PHO_RSC_BUF_HI 2
`define PHO_RSC_BUF_LO 1
`define PHO_HOC_EN0 0
`define PHO_HOC_EXT 1
`define PHO_HOC_EN2 2
`define PHO_HOC_CMP 3
`define PHO_STS_DLD 0
`define PHO_STS_MON_HI 3
`define PHO_STS_MON_LO 1
`define PHO_STS_HIZ 4

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define PHO_LPS_CURSRC 6'h04
`define PHO_LDC_CNT0 8'h05
`define PHO_LDC_CNT1 8'h10
`define PHO_LDC_CNT2 8'h40
`define PHO_LDC_CNT3 8'hff

`endif

// [design/pho_holdover.v]
// Notes on behaviour
// [RULE1] Holdover means charge pump output high impedance
// [RULE2] Both enable bits needed for any holdover
// [RULE3] External bit: pin mode; clear: lock-loss mode
// [RULE4] Resync falling edge enters holdover at once
// [RULE5] Exit only on next reference detector edge
// [RULE6] Pulse feedback counter reset at exit
// [RULE7] Automatic mode enters on low lock indicator
// [RULE8] Comparator off: lock indicator seen high
// [RULE9] Stay high impedance while reference absent
// [RULE10] Re-entry blocked until relocked and pin high
// [RULE11] Holdover follows selected reference, ends next edge
// [RULE12] Lock count field; code zero means five
// [RULE13] Software must keep lock detector enabled
// [RULE14] Window bit zero selects high range
// [RULE15] Code 000100b selects current source lock mode
// [RULE16] Buffer field 11b enables both reference buffers
// [RULE17] Software disables holdover around oscillator calibration
// [RULE18] Software sets dividers to ignore resync pin
// [RULE19] Three frequency monitors reported in status
// [RULE20] Field selects monitor threshold range
// [RULE21] Lock after N in-window, unlock on one
// [RULE22] Current source charges only while locked
// [RULE23] Pins synchronised before edge and state decisions
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pho_defines.vh"

module pho_holdover (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [11:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Pins and analog sense inputs
	input wire resync_pin_i,
	input wire lock_cmp_i,
	input wire ref_pfd_i,
	input wire in_window_i,
	input wire beyond_unlock_i,
	input wire first_reference_input_low_i,
	input wire second_reference_input_low_i,
	input wire vco_low_i,
	// Charge pump and divider control
	output reg cp_hiz_o,
	output reg b_cnt_reset_o,
	// Lock indicator pin drive
	output reg lock_pin_o,
	output reg lock_pin_oe_n_o,
	output reg cs_charge_o,
	output reg cs_mode_o,
	// Analog configuration
	output reg ld_window_high_o,
	output reg [2:0] mon_thr_sel_o,
	output reg [1:0] ref_buf_en_o
);

	parameter [7:0] CNT1 = `PHO_LDC_CNT1;
	parameter [7:0] CNT2 = `PHO_LDC_CNT2;
	parameter [7:0] CNT3 = `PHO_LDC_CNT3;

	localparam NPIN = 8;
	localparam [1:0] ST_RUN = 2'h0;
	localparam [1:0] ST_HOLD = 2'h1;
	localparam [1:0] ST_REARM = 2'h2;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [NPIN-1:0] pin_raw;
	reg [NPIN-1:0] s1_ff;
	reg [NPIN-1:0] s2_ff;
	reg [NPIN-1:0] s3_ff;
	reg [NPIN-1:0] st_ff;
	assign pin_raw = {vco_low_i, second_reference_input_low_i, first_reference_input_low_i, beyond_unlock_i,
		in_window_i, ref_pfd_i, lock_cmp_i, resync_pin_i};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			always @(posedge clk_i) begin
				if (rst_i) begin
					// Resync idles high: all stages start high, no false edge
					s1_ff[gi] <= (gi == 0) ? 1'b1 : 1'b0;
					s2_ff[gi] <= (gi == 0) ? 1'b1 : 1'b0;
					s3_ff[gi] <= (gi == 0) ? 1'b1 : 1'b0;
					st_ff[gi] <= (gi == 0) ? 1'b1 : 1'b0;
				end else begin
					s1_ff[gi] <= pin_raw[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					// Change counts once two stages agree [RULE23]
					if (s2_ff[gi] == s3_ff[gi])
						st_ff[gi] <= s3_ff[gi];
				end
			end
		end
	endgenerate

	wire resync_s = st_ff[0];
	wire lock_cmp_s = st_ff[1];
	wire ref_pfd_s = st_ff[2];
	wire in_win_s = st_ff[3];
	wire beyond_s = st_ff[4];
	wire [2:0] mon_s = st_ff[7:5];

	reg resync_d_ff;
	reg ref_pfd_d_ff;
	wire resync_fall = resync_d_ff & ~resync_s; // [RULE4]
	wire ref_edge = ref_pfd_s & ~ref_pfd_d_ff;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] ldc_ff;
	reg [7:0] lps_ff;
	reg [7:0] mpt_ff;
	reg [7:0] rsc_ff;
	reg [7:0] hoc_ff;
	reg dld_ff;
	reg [7:0] lock_cnt_ff;
	reg [1:0] state_ff;

	wire [9:0] idx = wb_adr_i[11:2];
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr_en = wb_req & wb_we_i & wb_sel_i[0];
	wire [7:0] sts = {3'h0, cp_hiz_o, mon_s, dld_ff}; // [RULE19]

	reg [7:0] rd_byte;
	always @* begin
		case (idx)
			`PHO_IDX_LDC: rd_byte = ldc_ff;
			`PHO_IDX_LPS: rd_byte = lps_ff;
			`PHO_IDX_MPT: rd_byte = mpt_ff;
			`PHO_IDX_RSC: rd_byte = rsc_ff;
			`PHO_IDX_HOC: rd_byte = hoc_ff;
			`PHO_IDX_STS: rd_byte = sts;
			default: rd_byte = 8'h00;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ldc_ff <= `PHO_RST_LDC;
			lps_ff <= `PHO_RST_LPS;
			mpt_ff <= `PHO_RST_MPT;
			rsc_ff <= `PHO_RST_RSC;
			hoc_ff <= `PHO_RST_HOC;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req)
				wb_dat_o <= {24'h000000, rd_byte};
			if (wr_en) begin
				case (idx)
					`PHO_IDX_LDC: ldc_ff <= wb_dat_i[7:0];
					`PHO_IDX_LPS: lps_ff <= wb_dat_i[7:0];
					`PHO_IDX_MPT: mpt_ff <= wb_dat_i[7:0];
					`PHO_IDX_RSC: rsc_ff <= wb_dat_i[7:0];
					`PHO_IDX_HOC: hoc_ff <= wb_dat_i[7:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Digital lock detector
	// ----------------------------------------
	// Evaluated once per reference detector event
	reg [7:0] lock_target;
	always @* begin
		case (ldc_ff[`PHO_LDC_CNT_HI:`PHO_LDC_CNT_LO])
			2'h0: lock_target = `PHO_LDC_CNT0; // [RULE12]
			2'h1: lock_target = CNT1;
			2'h2: lock_target = CNT2;
			default: lock_target = CNT3;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			dld_ff <= 1'b0;
			lock_cnt_ff <= 8'h00;
		end else if (ldc_ff[`PHO_LDC_DLD_DIS]) begin
			// Disabled detector never locks, so auto holdover sticks in ST_REARM after one exit [RULE13]
			dld_ff <= 1'b0;
			lock_cnt_ff <= 8'h00;
		end else if (ref_edge) begin
			if (beyond_s) begin
				dld_ff <= 1'b0; // [RULE21]
				lock_cnt_ff <= 8'h00;
			end else if (in_win_s) begin
				if (lock_cnt_ff + 8'h01 >= lock_target)
					dld_ff <= 1'b1; // [RULE21]
				if (lock_cnt_ff != 8'hff)
					lock_cnt_ff <= lock_cnt_ff + 8'h01;
			end else begin
				// Between thresholds: keep indication, restart count
				lock_cnt_ff <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Holdover state machine
	// ----------------------------------------
	wire ho_en = hoc_ff[`PHO_HOC_EN0] & hoc_ff[`PHO_HOC_EN2]; // [RULE2]
	wire ext_mode = hoc_ff[`PHO_HOC_EXT]; // [RULE3]
	// Comparator off reads as locked [RULE8]
	wire lock_eff = hoc_ff[`PHO_HOC_CMP] ? lock_cmp_s : 1'b1;

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_RUN;
			resync_d_ff <= 1'b1;
			ref_pfd_d_ff <= 1'b0;
			b_cnt_reset_o <= 1'b0;
		end else begin
			resync_d_ff <= resync_s;
			ref_pfd_d_ff <= ref_pfd_s;
			b_cnt_reset_o <= 1'b0;
			if (!ho_en) begin
				state_ff <= ST_RUN; // [RULE2]
			end else begin
				case (state_ff)
					ST_RUN: begin
						if (ext_mode && resync_fall)
							state_ff <= ST_HOLD; // [RULE4]
						else if (!ext_mode && !lock_eff)
							state_ff <= ST_HOLD; // [RULE7]
					end
					ST_HOLD: begin
						// No reference edge, no exit [RULE9] [RULE11]
						if (ref_edge && (!ext_mode || resync_s)) begin
							state_ff <= ext_mode ? ST_RUN : ST_REARM; // [RULE5]
							b_cnt_reset_o <= 1'b1; // [RULE6]
						end
					end
					ST_REARM: begin
						// Chattering lock detect would retrigger here [RULE10]
						if (ext_mode || (dld_ff && lock_eff))
							state_ff <= ST_RUN;
					end
					default: state_ff <= ST_RUN;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Output drive
	// ----------------------------------------
	wire cs_sel = (lps_ff[`PHO_LPS_SEL_HI:`PHO_LPS_SEL_LO] == `PHO_LPS_CURSRC); // [RULE15]
	wire hold_next = ho_en & ((state_ff == ST_HOLD) |
		((state_ff == ST_RUN) & ((ext_mode & resync_fall) | (~ext_mode & ~lock_eff))));

	always @(posedge clk_i) begin
		if (rst_i) begin
			cp_hiz_o <= 1'b0;
			lock_pin_o <= 1'b0;
			lock_pin_oe_n_o <= 1'b0;
			cs_charge_o <= 1'b0;
			cs_mode_o <= 1'b0;
			ld_window_high_o <= 1'b1;
			mon_thr_sel_o <= 3'h0;
			ref_buf_en_o <= 2'h0;
		end else begin
			// Leaves high impedance on the same edge as counter reset [RULE1]
			cp_hiz_o <= hold_next & ~(state_ff == ST_HOLD & ref_edge &
				(~ext_mode | resync_s));
			cs_mode_o <= cs_sel;
			// Any false indication discharges at once [RULE22]
			cs_charge_o <= cs_sel & dld_ff;
			lock_pin_o <= dld_ff;
			lock_pin_oe_n_o <= 1'b0;
			ld_window_high_o <= ~ldc_ff[`PHO_LDC_WIN]; // [RULE14]
			mon_thr_sel_o <= mpt_ff[`PHO_MPT_THR_HI:`PHO_MPT_THR_LO]; // [RULE20]
			ref_buf_en_o <= rsc_ff[`PHO_RSC_BUF_HI:`PHO_RSC_BUF_LO]; // [RULE16]
		end
	end

endmodule

`default_nettype wire

// [verification/pho_holdover_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module pho_holdover_chk (
	// Clock and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Pins and pump
	input wire logic resync_pin_i,
	input wire logic lock_cmp_i,
	input wire logic ref_pfd_i,
	input wire logic cp_hiz_o,
	input wire logic b_cnt_reset_o,
	input wire logic lock_pin_o,
	input wire logic lock_pin_oe_n_o,
	input wire logic cs_charge_o,
	input wire logic cs_mode_o
);
	// ---
	// Ages since a holdover request and since a raw reference edge
	// ---
	logic [4:0] pin_age_ff;
	logic [4:0] ref_age_ff;
	logic ref_d_ff;
	always_ff @(posedge clk_i) begin
		ref_d_ff <= ref_pfd_i;
		if (rst_i || !resync_pin_i || !lock_cmp_i)
			pin_age_ff <= rst_i ? 5'h1f : 5'h00;
		else
			pin_age_ff <= pin_age_ff + {4'h0, pin_age_ff != 5'h1f};
		if (rst_i || (ref_pfd_i && !ref_d_ff))
			ref_age_ff <= rst_i ? 5'h1f : 5'h00;
		else
			ref_age_ff <= ref_age_ff + {4'h0, ref_age_ff != 5'h1f};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	brst_pulse_a: assert property (b_cnt_reset_o |=> !b_cnt_reset_o) else $error("counter reset too long");
	brst_exit_a: assert property (b_cnt_reset_o |-> !cp_hiz_o && $past(cp_hiz_o)) else $error("reset not at exit");
	exit_on_ref_a: assert property (b_cnt_reset_o |-> ref_age_ff < 5'd10) else $error("exit without ref edge");
	hiz_cause_a: assert property ($rose(cp_hiz_o) |-> pin_age_ff < 5'd10) else $error("pump floated uncaused");
	pin_driven_a: assert property (!lock_pin_oe_n_o) else $error("lock pin not driven");
	charge_lock_a: assert property (cs_charge_o |-> lock_pin_o && cs_mode_o) else $error("charge without lock");
endmodule
bind pho_holdover pho_holdover_chk i_pho_holdover_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .resync_pin_i(resync_pin_i), .lock_cmp_i(lock_cmp_i),
	.ref_pfd_i(ref_pfd_i), .cp_hiz_o(cp_hiz_o), .b_cnt_reset_o(b_cnt_reset_o), .lock_pin_o(lock_pin_o),
	.lock_pin_oe_n_o(lock_pin_oe_n_o), .cs_charge_o(cs_charge_o), .cs_mode_o(cs_mode_o));
`default_nettype wire

// [verification/pho_ref_model.sv]
`timescale 1ns/1ns
`default_nettype none
module pho_ref_model (
	// Clock
	input wire logic clk_i,
	// Reference side
	output logic ref_pfd_o,
	output logic in_window_o,
	output logic beyond_unlock_o
);
	initial begin
		ref_pfd_o = 1'b0;
		in_window_o = 1'b0;
		beyond_unlock_o = 1'b0;
	end
	// Five clocks per phase so the synchroniser sees every edge
	task automatic send(input int n, input logic bad);
		repeat (n) begin
			@(posedge clk_i);
			in_window_o <= !bad;
			beyond_unlock_o <= bad;
			ref_pfd_o <= 1'b1;
			repeat (5) @(posedge clk_i);
			ref_pfd_o <= 1'b0;
			in_window_o <= bad;
			beyond_unlock_o <= !bad;
			repeat (5) @(posedge clk_i);
		end
	endtask
endmodule
`default_nettype wire

// [verification/pho_holdover_tb_top.sv]
`include "pho_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module pho_holdover_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, resync = 1'b1, lcmp = 1'b1, r1 = 1'b0, r2 = 1'b0, vl = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] dat = 32'h0, rdat;
	logic ref_pfd, in_win, bey, ack, hiz, brst, lpin, oen, csc, csm, winh;
	logic [2:0] thr;
	logic [1:0] buf_en;
	logic [7:0] t, m[int];
	logic [9:0] idx[7] = '{`PHO_IDX_LDC, `PHO_IDX_LPS, `PHO_IDX_MPT, `PHO_IDX_RSC, `PHO_IDX_HOC, `PHO_IDX_STS, 10'h019};
	int error_cnt = 0, compares = 0, cyc_cnt = 0;
	always #25 clk_i = ~clk_i;
	pho_holdover i_pho_holdover (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .resync_pin_i(resync),
		.lock_cmp_i(lcmp), .ref_pfd_i(ref_pfd), .in_window_i(in_win), .beyond_unlock_i(bey), .first_reference_input_low_i(r1),
		.second_reference_input_low_i(r2), .vco_low_i(vl), .cp_hiz_o(hiz), .b_cnt_reset_o(brst), .lock_pin_o(lpin),
		.lock_pin_oe_n_o(oen), .cs_charge_o(csc), .cs_mode_o(csm), .ld_window_high_o(winh),
		.mon_thr_sel_o(thr), .ref_buf_en_o(buf_en));
	pho_ref_model i_pho_ref_model (.clk_i(clk_i), .ref_pfd_o(ref_pfd), .in_window_o(in_win), .beyond_unlock_o(bey));
	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		compares++;
		if (a !== e) begin
			error_cnt++;
			$display("[ERR] %0t %h %h", $time, a, e);
		end
	endtask
	task report_and_stop;
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Classic cycle; read data compared with e on every read (e defaults to 0)
	task automatic wb(input logic w, input logic [9:0] ix, input logic [7:0] d, input logic [31:0] e = 32'h0);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		dat <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		if (!w) chk(rdat, e);
		if (w && ix inside {[`PHO_IDX_LDC:`PHO_IDX_HOC]} && ix != 10'h019) m[ix] = d;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	initial begin
		void'($urandom(54639));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++) wb(0, idx[i], 8'h0, 32'h0);
		for (int i = 0; i < 7; i++) begin
			wb(1, idx[i], 8'($urandom));
			wb(0, idx[i], 8'h0, m.exists(idx[i]) ? {24'h0, m[idx[i]]} : 32'h0);
		end
		t = 8'($urandom);
		// Holdover enabled last, once the loop setup is done
		// Dividers outside this block ignore the resync pin
		wb(1, `PHO_IDX_LDC, 8'h00);
		wb(1, `PHO_IDX_LPS, 8'h04);
		wb(1, `PHO_IDX_MPT, t);
		wb(1, `PHO_IDX_RSC, 8'h06);
		wb(1, `PHO_IDX_HOC, 8'h0d);
		chk(winh, 1'b1);
		chk(csm, 1'b1);
		chk(buf_en, 2'b11);
		chk(thr, t[7:5]);
		i_pho_ref_model.send(4, 1'b0);
		chk(lpin, 1'b0);
		i_pho_ref_model.send(1, 1'b0);
		chk(lpin, 1'b1);
		chk(csc, 1'b1);
		{r1, r2, vl} <= 3'($urandom);
		repeat (6) @(posedge clk_i);
		wb(0, `PHO_IDX_STS, 8'h0, {28'h0, vl, r2, r1, 1'b1});
		lcmp <= 1'b0;
		repeat (30) @(posedge clk_i);
		chk(hiz, 1'b1);
		i_pho_ref_model.send(1, 1'b0);
		repeat (10) @(posedge clk_i);
		chk(hiz, 1'b0);
		lcmp <= 1'b1;
		repeat (10) @(posedge clk_i);
		lcmp <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk(hiz, 1'b1);
		lcmp <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk(hiz, 1'b1);
		i_pho_ref_model.send(1, 1'b0);
		chk(hiz, 1'b0);
		wb(1, `PHO_IDX_HOC, 8'h05);
		lcmp <= 1'b0;
		resync <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk(hiz, 1'b0);
		lcmp <= 1'b1;
		i_pho_ref_model.send(1, 1'b1);
		chk(lpin, 1'b0);
		chk(csc, 1'b0);
		wb(1, `PHO_IDX_HOC, 8'h07);
		repeat (10) @(posedge clk_i);
		chk(hiz, 1'b0);
		resync <= 1'b1;
		repeat (10) @(posedge clk_i);
		resync <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk(hiz, 1'b1);
		resync <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk(hiz, 1'b1);
		i_pho_ref_model.send(1, 1'b0);
		chk(hiz, 1'b0);
		foreach (idx[i]) if (i < 2) begin
			wb(1, `PHO_IDX_HOC, i ? 8'h06 : 8'h03);
			resync <= 1'b0;
			repeat (10) @(posedge clk_i);
			chk(hiz, 1'b0);
			resync <= 1'b1;
			repeat (10) @(posedge clk_i);
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
